/* design/dram_defines.svh */
`ifndef DRAM_DEFINES_SVH
`define DRAM_DEFINES_SVH

// channel geometry
`define DRAM_BANKS        8
`define DRAM_BANK_W       3
`define DRAM_ROW_W        14
`define DRAM_COL_W        10
`define DRAM_COL_DROP     2
`define DRAM_CA_W         6
`define DRAM_DQ_W         16
`define DRAM_PREFETCH     16
`define DRAM_FETCH_BITS   256
`define DRAM_FETCH_LSB    4

// command frame: beats sampled per command, payload bits after beat 0
`define DRAM_FRAME_BEATS  4
`define DRAM_ADDR_SH_W    18
`define DRAM_BEAT_W       2

// opcode field in beat 0 of a frame
`define DRAM_OP_MSB       5
`define DRAM_OP_LSB       3
`define DRAM_OP_ACT       3'h1
`define DRAM_OP_RD        3'h2
`define DRAM_OP_WR        3'h3
`define DRAM_OP_PRE       3'h4

// data staging
`define DRAM_FIFO_DEPTH   32
`define DRAM_MEM_AW       4
`define DRAM_SLOT_W       4

`endif

/* design/dram_pkg.sv */
package dram_pkg;

  // channel sequencing states, gray along idle -> cmd -> write data only
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_CMD   = 2'h1,
    ST_WDATA = 2'h3,
    ST_RFILL = 2'h2
  } chan_state_t;

endpackage

/* design/burst_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module burst_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wr_ptr_r;
  logic [AW:0]  rd_ptr_r;
  logic         push;
  logic         pop;

  // extra pointer bit tells full from empty
  assign in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* design/dram_channel.sv */
// Behaviour
// - one active-low die reset clears every channel of the die
// - boundary-scan connectivity test runs only while scan enable is high
// - eight banks, chosen by three bank bits on activate, read, write
// - 16384 rows per bank, fourteen-bit row taken with activate
// - ten-bit column; lowest two column bits never sent, taken as zero
// - every read or write moves 256 bits between array and interface
// - activate bank and row bits pick which bank and row open
// - read or write bits pick target bank and burst start column
// - data pins double data rate; core uses sixteen-wide prefetch
// - one full-width core transfer per access, pins serialise half-cycles
// - bursts start at chosen column, run set length in set order
// - command inputs sampled where rising true clock crosses falling complement
// - chip select is part of command code; one per channel
`timescale 1ns/1ps
`default_nettype none
`include "dram_defines.svh"
module dram_channel
  import dram_pkg::*;
#(
  parameter int BANKS  = `DRAM_BANKS,
  parameter int DQ_W   = `DRAM_DQ_W,
  parameter int FIFO_D = `DRAM_FIFO_DEPTH,
  parameter int MEM_AW = `DRAM_MEM_AW
) (
  input  wire logic                     clock,
  input  wire logic                     rstn,
  input  wire logic                     clock_true,
  input  wire logic                     clock_complement,
  input  wire logic                     chip_select,
  input  wire logic [`DRAM_CA_W-1:0]    command_address_bus,
  input  wire logic [DQ_W-1:0]          dq_in,
  output logic      [DQ_W-1:0]          dq_out,
  output logic                          dq_oe,
  input  wire logic                     scan_test_enable,
  output logic                          scan_active,
  output logic      [BANKS-1:0]         bank_open_mask
);

  localparam int SYNC_W = 4 + `DRAM_CA_W + DQ_W;
  localparam int MEM_N  = 1 << MEM_AW;

  //////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SYNC_W-1:0]     pin_meta_r;
  logic [SYNC_W-1:0]     pin_sync_r;
  logic                  ck_t_s;
  logic                  ck_c_s;
  logic                  cs_s;
  logic                  scan_s;
  logic [`DRAM_CA_W-1:0] ca_s;
  logic [DQ_W-1:0]       dq_s;
  logic                  ck_prev_r;
  logic                  ck_rise;
  logic                  ck_edge;

  // all pins except rstn share one two-stage synchroniser so they stay aligned
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {clock_true, clock_complement, chip_select,
                     scan_test_enable, command_address_bus, dq_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign {ck_t_s, ck_c_s, cs_s, scan_s, ca_s, dq_s} = pin_sync_r;

  // previous true clock level for edge finding
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ck_prev_r <= 1'b0;
    end else begin
      ck_prev_r <= ck_t_s;
    end
  end

  assign ck_rise = ck_t_s & ~ck_prev_r & ~ck_c_s;
  assign ck_edge = ck_t_s ^ ck_prev_r;

  //////////////////////////////////////////////////////////////////////////
  // command frame decode

  chan_state_t                   state_r;
  logic [`DRAM_BEAT_W-1:0]       beat_r;
  logic [2:0]                    op_r;
  logic [`DRAM_BANK_W-1:0]       bank_r;
  logic [`DRAM_ADDR_SH_W-1:0]    addr_sh_r;
  logic [`DRAM_ADDR_SH_W-1:0]    addr_sh_nxt;
  logic                          frame_done;
  logic [BANKS-1:0]              open_r;
  logic [`DRAM_ROW_W-1:0]        row_r [BANKS];
  logic [`DRAM_COL_W-1:0]        col_nxt;
  logic [`DRAM_SLOT_W-1:0]       start_r;
  logic [`DRAM_SLOT_W-1:0]       cnt_r;
  logic [MEM_AW-1:0]             idx_r;
  logic [MEM_AW-1:0]             idx_nxt;
  logic                          access_ok;
  logic                          last_slot;
  logic                          fifo_in_ready;

  assign addr_sh_nxt = {addr_sh_r[`DRAM_ADDR_SH_W-`DRAM_CA_W-1:0], ca_s};
  assign frame_done  = (state_r == ST_CMD) && ck_rise &&
                       (beat_r == `DRAM_BEAT_W'(`DRAM_FRAME_BEATS - 1));
  assign col_nxt     = {addr_sh_nxt[`DRAM_COL_W-`DRAM_COL_DROP-1:0],
                        `DRAM_COL_DROP'(0)};
  assign access_ok   = open_r[bank_r];
  assign last_slot   = cnt_r == `DRAM_SLOT_W'(`DRAM_PREFETCH - 1);

  // storage index: fetch boundary folded with bank and its open row;
  // the array is a small model, so distinct addresses may alias
  // row from activate
  assign idx_nxt = MEM_AW'(col_nxt[`DRAM_COL_W-1:`DRAM_FETCH_LSB]) ^
                   MEM_AW'(row_r[bank_r]) ^ MEM_AW'(bank_r);

  // frame sequencing; cs only marks beat 0 of a frame
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      beat_r    <= '0;
      op_r      <= '0;
      bank_r    <= '0;
      addr_sh_r <= '0;
      start_r   <= '0;
      cnt_r     <= '0;
      idx_r     <= '0;
    end else if (scan_s) begin
      // scan owns the pins, commands dropped
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (ck_rise && cs_s) begin
            op_r    <= ca_s[`DRAM_OP_MSB:`DRAM_OP_LSB];
            bank_r  <= ca_s[`DRAM_BANK_W-1:0];
            beat_r  <= `DRAM_BEAT_W'(1);
            state_r <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (ck_rise) begin
            addr_sh_r <= addr_sh_nxt;
            beat_r    <= beat_r + 1'b1;
          end
          if (frame_done) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
            // bank and start column from read or write
            start_r <= col_nxt[`DRAM_SLOT_W-1:0];
            idx_r   <= idx_nxt;
            if (access_ok && op_r == `DRAM_OP_RD) begin
              state_r <= ST_RFILL;
            end
            if (access_ok && op_r == `DRAM_OP_WR) begin
              state_r <= ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (ck_edge) begin
            cnt_r <= cnt_r + 1'b1;
            if (last_slot) begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_RFILL: begin
          if (fifo_in_ready) begin
            cnt_r <= cnt_r + 1'b1;
            if (last_slot) begin
              state_r <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-bank open rows

  genvar gb;
  generate
    for (gb = 0; gb < BANKS; gb++) begin : g_bank
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          open_r[gb] <= 1'b0;
          row_r[gb]  <= '0;
        end else if (frame_done && bank_r == `DRAM_BANK_W'(gb)) begin
          if (op_r == `DRAM_OP_ACT) begin
            open_r[gb] <= 1'b1;
            row_r[gb]  <= addr_sh_nxt[`DRAM_ROW_W-1:0];
          end
          if (op_r == `DRAM_OP_PRE) begin
            open_r[gb] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // core array and burst staging

  logic [`DRAM_FETCH_BITS-1:0] mem_r [MEM_N];
  logic [`DRAM_FETCH_BITS-1:0] wbuf_r;
  logic [`DRAM_FETCH_BITS-1:0] rbuf_r;
  logic [`DRAM_SLOT_W-1:0]     slot;
  logic                        commit_r;

  assign slot = start_r + cnt_r;

  // write beats land in their wrapped slot of the fetch word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wbuf_r <= '0;
    end else if (state_r == ST_WDATA && ck_edge) begin
      wbuf_r[slot*DQ_W +: DQ_W] <= dq_s;
    end
  end

  // commit pulse follows the last write beat
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      commit_r <= 1'b0;
    end else begin
      commit_r <= state_r == ST_WDATA && ck_edge && last_slot;
    end
  end

  // full 256-bit fetch written at once
  always_ff @(posedge clock) begin
    if (commit_r) begin
      mem_r[idx_r] <= wbuf_r;
    end
  end

  // whole fetch read in one cycle, then serialised
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rbuf_r <= '0;
    end else if (frame_done) begin
      rbuf_r <= mem_r[idx_nxt];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read fifo and pin drive

  logic            fifo_out_valid;
  logic [DQ_W-1:0] fifo_out_data;
  logic            fifo_pop;

  // the core fills far faster than pins drain, but the fifo holds two bursts, so
  // only a third read could stall on a full fifo; the fill sequencer simply waits
  burst_fifo #(
    .W     (DQ_W),
    .DEPTH (FIFO_D)
  ) u_rd_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (state_r == ST_RFILL),
    .in_data   (rbuf_r[slot*DQ_W +: DQ_W]),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_pop)
  );

  assign fifo_pop = ck_edge & fifo_out_valid & ~scan_s;

  // drive pins: one word per half link cycle, released when empty
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else if (scan_s) begin
      dq_out <= DQ_W'({ck_c_s, ck_t_s, cs_s, ca_s});
      dq_oe  <= 1'b1;
    end else if (ck_edge) begin
      dq_out <= fifo_out_valid ? fifo_out_data : '0;
      dq_oe  <= fifo_out_valid;
    end else if (scan_active) begin
      // scan just left, pins released without waiting for a link edge
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end
  end

  // status outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scan_active    <= 1'b0;
      bank_open_mask <= '0;
    end else begin
      scan_active    <= scan_s;
      bank_open_mask <= open_r;
    end
  end

endmodule
`default_nettype wire

/* test/dram_channel_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dram_defines.svh"
module dram_channel_checker #(
  parameter int BANKS = 8,
  parameter int DQ_W  = 16
) (
  input wire logic                  clock,
  input wire logic                  rstn,
  input wire logic                  clock_true,
  input wire logic                  clock_complement,
  input wire logic                  chip_select,
  input wire logic [`DRAM_CA_W-1:0] command_address_bus,
  input wire logic [DQ_W-1:0]       dq_in,
  input wire logic [DQ_W-1:0]       dq_out,
  input wire logic                  dq_oe,
  input wire logic                  scan_test_enable,
  input wire logic                  scan_active,
  input wire logic [BANKS-1:0]      bank_open_mask
);
  logic       link_q_r;
  logic [3:0] rise_age_r;
  logic [3:0] edge_age_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // ages of the last link edges; they saturate so an idle link never wraps
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_q_r   <= 1'b0;
      rise_age_r <= 4'hF;
      edge_age_r <= 4'hF;
    end else begin
      link_q_r   <= clock_true;
      if (clock_true && !link_q_r) rise_age_r <= 4'h0;
      else if (rise_age_r != 4'hF) rise_age_r <= rise_age_r + 4'h1;
      if (clock_true != link_q_r) edge_age_r <= 4'h0;
      else if (edge_age_r != 4'hF) edge_age_r <= edge_age_r + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  a_reset_clears_outputs: assert property (disable iff (1'b0)
    !rstn && !$past(rstn) |-> bank_open_mask == '0 && !dq_oe)
    else $error("outputs not cleared during reset");
  a_scan_turns_on: assert property (
    $rose(scan_test_enable) |-> ##[1:5] scan_active)
    else $error("scan mode not entered");
  a_scan_turns_off: assert property (
    $fell(scan_test_enable) |-> ##[1:5] !scan_active)
    else $error("scan mode not left");
  a_scan_freezes_banks: assert property (
    scan_active && $past(scan_active, 8) |-> $stable(bank_open_mask))
    else $error("bank state moved in scan mode");
  a_one_bank_moves: assert property (
    $changed(bank_open_mask)
      |-> $onehot(bank_open_mask ^ $past(bank_open_mask)))
    else $error("more than one bank changed at once");
  a_mask_follows_rise: assert property (
    $changed(bank_open_mask) |-> rise_age_r <= 4'hA)
    else $error("bank state changed without a link rise");
  a_dq_follows_edge: assert property (
    $changed(dq_out) && dq_oe && $past(dq_oe) && !scan_test_enable
      && !$past(scan_test_enable, 6) |-> edge_age_r <= 4'h8)
    else $error("read word changed without a link edge");
  a_drive_has_cause: assert property (
    dq_oe |-> bank_open_mask != '0 || scan_test_enable
      || $past(scan_test_enable, 6))
    else $error("data driven with no open bank");

  // main scenarios reached
  c_bank_opened: cover property ($rose(|bank_open_mask));
  c_read_driven: cover property (dq_oe && !scan_active);
  c_scan_entered: cover property ($rose(scan_active));
endmodule

bind dram_channel dram_channel_checker #(.BANKS(BANKS), .DQ_W(DQ_W))
  u_dram_channel_checker (.clock(clock), .rstn(rstn),
    .clock_true(clock_true), .clock_complement(clock_complement),
    .chip_select(chip_select), .command_address_bus(command_address_bus),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .scan_test_enable(scan_test_enable), .scan_active(scan_active),
    .bank_open_mask(bank_open_mask));
`default_nettype wire

/* test/dram_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dram_ctrl_model (
  input  wire logic        clock,
  output logic             clock_true,
  output logic             clock_complement,
  output logic             chip_select,
  output logic [5:0]       command_address_bus,
  output logic [15:0]      dq_in,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe
);
  logic [15:0] rd_word [16];
  logic        rd_oe   [17];

  // link parked low between frames
  initial begin
    clock_true = 1'b0;
    clock_complement = 1'b1;
    chip_select = 1'b0;
    command_address_bus = 6'h00;
    dq_in = 16'h0000;
  end

  // one link edge, complement always opposite the true clock
  task automatic link_edge(input int half);
    clock_true <= ~clock_true;
    clock_complement <= clock_true;
    repeat (half) @(posedge clock);
  endtask

  // four-beat frame, select only on beat 0; ends link high
  task automatic frame(input logic [2:0] op, input logic [2:0] bank,
                       input logic [17:0] arg);
    logic [23:0] beats;
    beats = {op, bank, arg};
    @(posedge clock);
    for (int b = 0; b < 4; b++) begin
      chip_select <= (b == 0);
      command_address_bus <= beats[23-6*b -: 6];
      repeat (2) @(posedge clock);
      link_edge(4);
      if (b < 3) link_edge(2);
    end
    chip_select <= 1'b0;
    command_address_bus <= ~beats[5:0];
  endtask

  // true clock rises while the complement stays high, so no crossing
  task automatic lone_rise(input logic [2:0] bank);
    @(posedge clock);
    chip_select <= 1'b1;
    command_address_bus <= {3'h1, bank};
    repeat (2) @(posedge clock);
    clock_true <= 1'b1;
    repeat (4) @(posedge clock);
    clock_true <= 1'b0;
    repeat (4) @(posedge clock);
    chip_select <= 1'b0;
  endtask

  // a word per link edge; bus inverted after the burst, not held
  task automatic wr_burst(input logic [15:0] w [16]);
    for (int k = 0; k < 16; k++) begin
      dq_in <= w[k];
      link_edge(4);
    end
    dq_in <= ~w[15];
    link_edge(4);
  endtask

  // slow link while reading, so each word is caught well settled
  task automatic rd_burst();
    repeat (24) @(posedge clock);
    for (int k = 0; k < 17; k++) begin
      link_edge(6);
      @(negedge clock);
      rd_oe[k] = dq_oe;
      if (k < 16) rd_word[k] = dq_out;
      repeat (2) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

/* test/dram_channel_addressing_access_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dram_defines.svh"
module dram_channel_addressing_access_test;
  logic clock, rstn, scan_test_enable, dq_oe, scan_active;
  logic clock_true, clock_complement, chip_select;
  logic [5:0]  command_address_bus;
  logic [15:0] dq_in, dq_out;
  logic [7:0]  bank_open_mask;
  logic [15:0] wdata [16];
  int          mismatches, compares;

  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  dram_channel u_dram_channel (.clock(clock), .rstn(rstn),
    .clock_true(clock_true), .clock_complement(clock_complement),
    .chip_select(chip_select), .command_address_bus(command_address_bus),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .scan_test_enable(scan_test_enable), .scan_active(scan_active),
    .bank_open_mask(bank_open_mask));
  dram_ctrl_model ctl (.clock(clock), .clock_true(clock_true),
    .clock_complement(clock_complement), .chip_select(chip_select),
    .command_address_bus(command_address_bus), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));

  //////////////////////////////////////////////////////////////////////////
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // open all eight banks with boundary rows, then close them again
  task automatic t_banks();
    logic [7:0] exp;
    exp = 8'h00;
    for (int p = 0; p < 16; p++) begin
      if (p < 8) ctl.frame(`DRAM_OP_ACT, 3'(p), {4'h0, 14'h3FFF - 14'(p)});
      else ctl.frame(`DRAM_OP_PRE, 3'(p), 18'h00000);
      ctl.link_edge(8);
      exp[p%8] = (p < 8);
      check_word({8'h00, bank_open_mask}, {8'h00, exp});
    end
  endtask

  // a rise without the complement crossing must not start a command
  task automatic t_crossing();
    ctl.lone_rise(3'h3);
    ctl.frame(`DRAM_OP_ACT, 3'h6, 18'h00042);
    ctl.link_edge(8);
    check_word({8'h00, bank_open_mask}, 16'h0040);
    ctl.frame(`DRAM_OP_PRE, 3'h6, 18'h00000);
    ctl.link_edge(8);
    check_word({8'h00, bank_open_mask}, 16'h0000);
  endtask

  // write from column 4, read back from column 0 and column 12, wrapping
  task automatic t_write_read();
    for (int k = 0; k < 16; k++) wdata[k] = {8'hC3, 4'(k), 4'(~k)};
    ctl.frame(`DRAM_OP_ACT, 3'h5, {4'h0, 14'h2A5F});
    ctl.link_edge(8);
    ctl.frame(`DRAM_OP_WR, 3'h5, 18'h00001);
    ctl.wr_burst(wdata);
    for (int r = 0; r < 2; r++) begin
      ctl.frame(`DRAM_OP_RD, 3'h5, (r == 0) ? 18'h00000 : 18'h00003);
      ctl.rd_burst();
      for (int k = 0; k < 16; k++) begin
        check_bit(ctl.rd_oe[k], 1'b1);
        check_word(ctl.rd_word[k], wdata[(k + 12 - 4 * r) % 16]);
      end
      check_bit(ctl.rd_oe[16], 1'b0);
    end
  endtask

  // a read to a bank just closed must leave the data pins alone
  task automatic t_closed();
    ctl.frame(`DRAM_OP_PRE, 3'h5, 18'h00000);
    ctl.link_edge(8);
    ctl.frame(`DRAM_OP_RD, 3'h5, 18'h00000);
    ctl.rd_burst();
    check_bit(ctl.rd_oe[0], 1'b0);
    check_bit(ctl.rd_oe[8], 1'b0);
  endtask

  // scan mirrors the command pins and ignores an activate
  task automatic t_scan();
    scan_test_enable <= 1'b1;
    repeat (8) @(posedge clock);
    @(negedge clock);
    check_bit(scan_active, 1'b1);
    check_bit(dq_oe, 1'b1);
    check_word(dq_out, {7'h00, clock_complement, clock_true, chip_select,
                        command_address_bus});
    ctl.frame(`DRAM_OP_ACT, 3'h2, 18'h00123);
    ctl.link_edge(8);
    check_word({8'h00, bank_open_mask}, 16'h0000);
    scan_test_enable <= 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    check_bit(scan_active, 1'b0);
    check_bit(dq_oe, 1'b0);
  endtask

  // die reset in mid-run closes the open bank; the channel then recovers
  task automatic t_die_reset();
    ctl.frame(`DRAM_OP_ACT, 3'h7, 18'h00000);
    ctl.link_edge(8);
    check_word({8'h00, bank_open_mask}, 16'h0080);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check_word({8'h00, bank_open_mask}, 16'h0000);
    check_bit(dq_oe, 1'b0);
    @(posedge clock);
    rstn <= 1'b1;
    repeat (8) @(posedge clock);
    ctl.frame(`DRAM_OP_ACT, 3'h1, 18'h01555);
    ctl.link_edge(8);
    check_word({8'h00, bank_open_mask}, 16'h0002);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence; reset held five cycles
  initial begin
    rstn = 1'b0;
    scan_test_enable = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (8) @(posedge clock);
    t_banks();
    t_crossing();
    t_write_read();
    t_closed();
    t_scan();
    t_die_reset();
    close_out();
  end

  // watchdog: several times the expected run of about 1620 cycles
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
